// *** rtl/swdv_top.sv ***
// Front switch interlock, differential outputs and virtual input zero
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
module swdv_top #(
  parameter int unsigned CYC_PER_MS = swdv_pkg::CYC_PER_MS
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic         extended_switch_input,
  input  wire logic [255:0] status_signals,
  input  wire logic         phase_a,
  input  wire logic         phase_b,
  output logic [7:0]        switch_func_code,
  output logic              switch_func_level,
  output logic              monitor_led,
  output logic              diff_output_a,
  output logic              diff_output_b,
  output logic              diff_output_en,
  output logic [7:0]        virtual_input_zero_code,
  output logic              virtual_input_zero
);
  import swdv_pkg::*;

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  logic [7:0] sw_func;
  logic       sw_inv;
  logic [7:0] rel_time;
  logic [7:0] rel_dur;
  logic [7:0] mon_time;
  logic [7:0] dmode;
  logic [7:0] a_src;
  logic       a_inv;
  logic [7:0] a_dly;
  logic [7:0] b_src;
  logic       b_inv;
  logic [7:0] b_dly;
  logic [7:0] v_func;
  logic [7:0] v_src;
  logic       v_inv;
  logic       v_shot;
  logic [7:0] v_dead;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  wire sel_sw   = (paddr == OFF_SW_CFG);
  wire sel_swt  = (paddr == OFF_SW_TIME);
  wire sel_dm   = (paddr == OFF_DMODE);
  wire sel_da   = (paddr == OFF_DA_CFG);
  wire sel_db   = (paddr == OFF_DB_CFG);
  wire sel_vin  = (paddr == OFF_VIN_CFG);
  wire sel_st   = (paddr == OFF_STATUS);
  wire hit      = sel_sw | sel_swt | sel_dm | sel_da | sel_db | sel_vin | sel_st;
  wire wr_en    = psel & penable & pwrite & hit;
  wire setup_rd = psel & ~penable & ~pwrite;

  // Zero wait states: read data is captured in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      sw_func  <= RST_SW_FUNC;
      sw_inv   <= 1'b0;
      rel_time <= RST_RTIME;
      rel_dur  <= RST_RDUR;
      mon_time <= RST_MON;
    end else if (wr_en && sel_sw) begin
      sw_func  <= pwdata[POS_FUNC +: 8];
      sw_inv   <= pwdata[POS_INV];
    end else if (wr_en && sel_swt) begin
      rel_time <= pwdata[POS_RTIME +: 8];
      rel_dur  <= pwdata[POS_RDUR +: 8];
      mon_time <= pwdata[POS_MON +: 8];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dmode <= RST_DMODE;
      a_src <= RST_DSRC;
      a_inv <= 1'b0;
      a_dly <= RST_DDLY;
      b_src <= RST_DSRC;
      b_inv <= 1'b0;
      b_dly <= RST_DDLY;
    end else if (wr_en && sel_dm) begin
      dmode <= pwdata[7:0];
    end else if (wr_en && sel_da) begin
      a_src <= pwdata[POS_DSRC +: 8];
      a_inv <= pwdata[POS_DINV];
      a_dly <= pwdata[POS_DDLY +: 8];
    end else if (wr_en && sel_db) begin
      b_src <= pwdata[POS_DSRC +: 8];
      b_inv <= pwdata[POS_DINV];
      b_dly <= pwdata[POS_DDLY +: 8];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      v_func <= RST_VFUNC;
      v_src  <= RST_VSRC;
      v_inv  <= 1'b0;
      v_shot <= 1'b0;
      v_dead <= RST_VDEAD;
    end else if (wr_en && sel_vin) begin
      v_func <= pwdata[POS_VFUNC +: 8];
      v_src  <= pwdata[POS_VSRC +: 8];
      v_inv  <= pwdata[POS_VINV];
      v_shot <= pwdata[POS_VSHOT];
      v_dead <= pwdata[POS_VDEAD +: 8];
    end
  end

  // ---------------------------------------------------------------
  // Time base: 1 ms and 0.1 s ticks
  // ---------------------------------------------------------------
  logic [17:0] ms_cnt;
  logic [6:0]  ds_cnt;
  wire         ms_tick = (ms_cnt == 18'(CYC_PER_MS - 1));
  wire         ds_tick = ms_tick && (ds_cnt == MS_PER_DSEC - 7'h01);

  always_ff @(posedge clk) begin
    if (rst || ms_tick) begin
      ms_cnt <= 18'h00000;
    end else begin
      ms_cnt <= ms_cnt + 18'h00001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || ds_tick) begin
      ds_cnt <= 7'h00;
    end else if (ms_tick) begin
      ds_cnt <= ds_cnt + 7'h01;
    end
  end

  // ---------------------------------------------------------------
  // Switch input synchroniser
  // ---------------------------------------------------------------
  logic sw_q1;
  logic sw_q2;
  logic sw_q3;
  logic pressed;

  // A level change counts only once the last two stages agree
  always_ff @(posedge clk) begin
    if (rst) begin
      sw_q1   <= 1'b0;
      sw_q2   <= 1'b0;
      sw_q3   <= 1'b0;
      pressed <= 1'b0;
    end else begin
      sw_q1 <= extended_switch_input;
      sw_q2 <= sw_q1;
      sw_q3 <= sw_q2;
      if (sw_q2 == sw_q3) begin
        pressed <= sw_q3;
      end
    end
  end

  // ---------------------------------------------------------------
  // Interlock
  // ---------------------------------------------------------------
  swdv_ilk_e ilk;
  swdv_ilk_e next_ilk;
  logic      hold_done;
  logic      win_done;
  wire       ilk_off  = (rel_time == 8'h00);
  wire       is_open  = (ilk == SWDV_OPEN);

  swdv_timer u_hold (
    .clk   (clk),
    .rst   (rst),
    .tick  (ds_tick),
    .run   (~is_open & pressed),
    .limit (rel_time),
    .done  (hold_done)
  );

  // Window timer stops running while the interlock is disabled
  swdv_timer u_win (
    .clk   (clk),
    .rst   (rst),
    .tick  (ds_tick),
    .run   (is_open & ~ilk_off),
    .limit (rel_dur),
    .done  (win_done)
  );

  always_comb begin
    next_ilk = ilk;
    case (ilk)
      SWDV_LOCKED: begin
        if (ilk_off || hold_done) begin
          next_ilk = SWDV_OPEN;
        end
      end
      SWDV_OPEN: begin
        if (win_done) begin
          next_ilk = SWDV_LOCKED;
        end
      end
      default: begin
        next_ilk = SWDV_LOCKED;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ilk <= SWDV_LOCKED;
    end else begin
      ilk <= next_ilk;
    end
  end

  // ---------------------------------------------------------------
  // Switch function and monitor LED
  // ---------------------------------------------------------------
  wire  sw_act = pressed & is_open;
  logic sw_act_d;
  logic led_on;
  logic led_done;

  swdv_timer u_led (
    .clk   (clk),
    .rst   (rst),
    .tick  (ds_tick),
    .run   (led_on),
    .limit (mon_time),
    .done  (led_done)
  );

  // A new press while lit keeps the LED on but does not restart its time
  always_ff @(posedge clk) begin
    if (rst) begin
      sw_act_d <= 1'b0;
      led_on   <= 1'b0;
    end else begin
      sw_act_d <= sw_act;
      if (sw_act && !sw_act_d) begin
        led_on <= 1'b1;
      end else if (led_done) begin
        led_on <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      switch_func_code  <= RST_SW_FUNC;
      switch_func_level <= 1'b0;
      monitor_led       <= 1'b0;
    end else begin
      switch_func_code  <= sw_func;
      switch_func_level <= sw_act ^ sw_inv;
      monitor_led       <= led_on & ~led_done;
    end
  end

  // ---------------------------------------------------------------
  // Differential outputs
  // ---------------------------------------------------------------
  wire  a_raw = (a_src == CODE_CONST_OFF) ? 1'b0 : status_signals[a_src];
  wire  b_raw = (b_src == CODE_CONST_OFF) ? 1'b0 : status_signals[b_src];
  wire  a_sig = a_raw ^ a_inv;
  wire  b_sig = b_raw ^ b_inv;
  logic a_hold;
  logic b_hold;
  logic a_done;
  logic b_done;

  swdv_timer u_adly (
    .clk   (clk),
    .rst   (rst),
    .tick  (ms_tick),
    .run   (a_hold & ~a_sig),
    .limit (a_dly),
    .done  (a_done)
  );

  swdv_timer u_bdly (
    .clk   (clk),
    .rst   (rst),
    .tick  (ms_tick),
    .run   (b_hold & ~b_sig),
    .limit (b_dly),
    .done  (b_done)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      a_hold <= 1'b0;
      b_hold <= 1'b0;
    end else begin
      a_hold <= a_sig | (a_hold & ~a_done);
      b_hold <= b_sig | (b_hold & ~b_done);
    end
  end

  wire a_eff   = a_sig | (a_hold & ~a_done);
  wire b_eff   = b_sig | (b_hold & ~b_done);
  wire mode_io = (dmode == DMODE_IO);
  wire mode_ab = (dmode == DMODE_AB);

  // Unlisted mode codes are treated like the no-output code
  always_ff @(posedge clk) begin
    if (rst) begin
      diff_output_a  <= 1'b0;
      diff_output_b  <= 1'b0;
      diff_output_en <= 1'b0;
    end else begin
      diff_output_a  <= mode_io ? a_eff : (mode_ab & phase_a);
      diff_output_b  <= mode_io ? b_eff : (mode_ab & phase_b);
      diff_output_en <= mode_io | mode_ab;
    end
  end

  // ---------------------------------------------------------------
  // Virtual input zero
  // ---------------------------------------------------------------
  wire  v_raw = (v_src == CODE_CONST_OFF) ? 1'b0 : status_signals[v_src];
  wire  v_sig = v_raw ^ v_inv;
  logic v_act;
  logic v_act_d;

  // Timer clears as soon as the trigger drops, so the input falls at once
  swdv_timer u_dead (
    .clk   (clk),
    .rst   (rst),
    .tick  (ms_tick),
    .run   (v_sig),
    .limit (v_dead),
    .done  (v_act)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      v_act_d                 <= 1'b0;
      virtual_input_zero      <= 1'b0;
      virtual_input_zero_code <= RST_VFUNC;
    end else begin
      v_act_d                 <= v_act;
      virtual_input_zero      <= v_shot ? (v_act & ~v_act_d) : v_act;
      virtual_input_zero_code <= v_func;
    end
  end

  // ---------------------------------------------------------------
  // Read back
  // ---------------------------------------------------------------
  wire [31:0] rd_sw  = {23'h0, sw_inv, sw_func};
  wire [31:0] rd_swt = {8'h00, mon_time, rel_dur, rel_time};
  wire [31:0] rd_dm  = {24'h000000, dmode};
  wire [31:0] rd_da  = {8'h00, a_dly, 7'h00, a_inv, a_src};
  wire [31:0] rd_db  = {8'h00, b_dly, 7'h00, b_inv, b_src};
  wire [31:0] rd_vin = {v_dead, 6'h00, v_shot, v_inv, v_src, v_func};
  wire [31:0] rd_st  = {26'h0000000, virtual_input_zero, diff_output_b, diff_output_a,
                        monitor_led, is_open, pressed};
  wire [31:0] rd_mux = sel_sw  ? rd_sw  :
                       sel_swt ? rd_swt :
                       sel_dm  ? rd_dm  :
                       sel_da  ? rd_da  :
                       sel_db  ? rd_db  :
                       sel_vin ? rd_vin :
                       sel_st  ? rd_st  : 32'h00000000;

  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (setup_rd) begin
      prdata <= rd_mux;
    end
  end

endmodule

// *** rtl/swdv_pkg.sv ***
// Constants shared by the switch, differential output and virtual input logic
package swdv_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned MS_TIME_PS    = 1000000000;
  localparam int unsigned CYC_PER_MS    = MS_TIME_PS / CLK_PERIOD_PS;
  localparam int unsigned DSEC_TIME_MS  = 100;
  localparam logic [6:0]  MS_PER_DSEC   = 7'(DSEC_TIME_MS);

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_SW_CFG  = 8'h00;
  localparam logic [7:0] OFF_SW_TIME = 8'h04;
  localparam logic [7:0] OFF_DMODE   = 8'h08;
  localparam logic [7:0] OFF_DA_CFG  = 8'h0C;
  localparam logic [7:0] OFF_DB_CFG  = 8'h10;
  localparam logic [7:0] OFF_VIN_CFG = 8'h14;
  localparam logic [7:0] OFF_STATUS  = 8'h18;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int unsigned POS_FUNC   = 0;
  localparam int unsigned POS_INV    = 8;
  localparam int unsigned POS_RTIME  = 0;
  localparam int unsigned POS_RDUR   = 8;
  localparam int unsigned POS_MON    = 16;
  localparam int unsigned POS_DSRC   = 0;
  localparam int unsigned POS_DINV   = 8;
  localparam int unsigned POS_DDLY   = 16;
  localparam int unsigned POS_VFUNC  = 0;
  localparam int unsigned POS_VSRC   = 8;
  localparam int unsigned POS_VINV   = 16;
  localparam int unsigned POS_VSHOT  = 17;
  localparam int unsigned POS_VDEAD  = 24;

  // ---------------------------------------------------------------
  // Codes and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] CODE_CONST_OFF = 8'h80;
  localparam logic [7:0] DMODE_NONE     = 8'hFF;
  localparam logic [7:0] DMODE_AB       = 8'h00;
  localparam logic [7:0] DMODE_IO       = 8'h08;
  localparam logic [7:0] RST_SW_FUNC    = 8'h09;
  localparam logic [7:0] RST_RTIME      = 8'h0A;
  localparam logic [7:0] RST_RDUR       = 8'h1E;
  localparam logic [7:0] RST_MON        = 8'h0A;
  localparam logic [7:0] RST_DMODE      = DMODE_AB;
  localparam logic [7:0] RST_DSRC       = CODE_CONST_OFF;
  localparam logic [7:0] RST_DDLY       = 8'h00;
  localparam logic [7:0] RST_VFUNC      = 8'h00;
  localparam logic [7:0] RST_VSRC       = CODE_CONST_OFF;
  localparam logic [7:0] RST_VDEAD      = 8'h00;

  // ---------------------------------------------------------------
  // Interlock states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SWDV_LOCKED = 2'b00,
    SWDV_OPEN   = 2'b01
  } swdv_ilk_e;

endpackage

// *** rtl/swdv_timer.sv ***
// Tick-based hold timer: counts ticks while run is high
`timescale 1ns/1ps
module swdv_timer (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       tick,
  input  wire logic       run,
  input  wire logic [7:0] limit,
  output logic            done
);

  logic [7:0] cnt;

  // Count clears whenever run drops, so only an unbroken run reaches the limit
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      cnt <= 8'h00;
    end else if (tick && cnt != 8'hFF) begin
      cnt <= cnt + 8'h01;
    end
  end

  assign done = run && (cnt >= limit);

endmodule

// *** test/swdv_checker.sv ***
// Assertion checker for the switch, differential output and virtual input logic
`timescale 1ns/1ps
module swdv_checker #(
  parameter int unsigned CYC_PER_MS = 10
) (
  input wire logic         clk,
  input wire logic         rst,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic [7:0]   paddr,
  input wire logic [31:0]  pwdata,
  input wire logic         pready,
  input wire logic         pslverr,
  input wire logic [255:0] status_signals,
  input wire logic [7:0]   switch_func_code,
  input wire logic         diff_output_a,
  input wire logic         diff_output_b,
  input wire logic         diff_output_en,
  input wire logic [7:0]   virtual_input_zero_code,
  input wire logic         virtual_input_zero
);
  import swdv_pkg::*;
  // ----------------------------
  // Shadow of written settings
  // ----------------------------
  logic [31:0] sw_w, mode_w, da_w, db_w, vin_w;
  logic        mapped, io, en_mode, sig_a, sig_b, sig_v;
  assign mapped  = (paddr[1:0] == 2'h0) && (paddr <= OFF_STATUS);
  assign io      = (mode_w[7:0] == DMODE_IO);
  assign en_mode = io || (mode_w[7:0] == DMODE_AB);
  // Code 128 reads as off whatever the status bus carries
  assign sig_a = ((da_w[7:0] != CODE_CONST_OFF) && status_signals[da_w[7:0]]) ^ da_w[8];
  assign sig_b = ((db_w[7:0] != CODE_CONST_OFF) && status_signals[db_w[7:0]]) ^ db_w[8];
  assign sig_v = ((vin_w[15:8] != CODE_CONST_OFF) && status_signals[vin_w[15:8]]) ^ vin_w[16];
  always_ff @(posedge clk) begin
    if (rst) begin
      sw_w   <= {24'h0, RST_SW_FUNC};
      mode_w <= {24'h0, RST_DMODE};
      da_w   <= {24'h0, RST_DSRC};
      db_w   <= {24'h0, RST_DSRC};
      vin_w  <= {16'h0, RST_VSRC, RST_VFUNC};
    end else if (psel && penable && pwrite) begin
      case (paddr)
        OFF_SW_CFG:  sw_w <= pwdata;
        OFF_DMODE:   mode_w <= pwdata;
        OFF_DA_CFG:  da_w <= pwdata;
        OFF_DB_CFG:  db_w <= pwdata;
        OFF_VIN_CFG: vin_w <= pwdata;
        default:     ;
      endcase
    end
  end
  // ----------------------------
  // Properties
  // ----------------------------
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  apb_ready_a: assert property (pready) else $error("pready low");
  apb_error_a: assert property (pslverr == (psel && penable && !mapped))
    else $error("pslverr differs from address decode");
  sw_code_a: assert property (switch_func_code == $past(sw_w[7:0]))
    else $error("switch function code differs from setting");
  vin_code_a: assert property (virtual_input_zero_code == $past(vin_w[7:0]))
    else $error("virtual input code differs from setting");
  diff_enable_a: assert property (!$past(rst) |-> diff_output_en == $past(en_mode))
    else $error("differential enable wrong for mode");
  diff_on_a: assert property (io && sig_a |=> diff_output_a)
    else $error("output a missed an ON");
  diff_off_a: assert property (io && !sig_a && da_w[23:16] == 8'h00 |=> !diff_output_a)
    else $error("output a held without delay");
  diffb_follow_a: assert property (io && db_w[23:16] == 8'h00 |=> diff_output_b == $past(sig_b))
    else $error("output b does not follow its source");
  vin_follow_a: assert property (vin_w[31:24] == 8'h00 && !vin_w[17]
    |=> virtual_input_zero == $past(sig_v))
    else $error("virtual input does not follow trigger");
  vin_drop_a: assert property (!sig_v |=> !virtual_input_zero)
    else $error("virtual input stayed on after trigger off");
  shot_pulse_a: assert property (vin_w[17] && virtual_input_zero |=> !virtual_input_zero)
    else $error("one-shot pulse longer than a cycle");
endmodule
bind swdv_top swdv_checker #(.CYC_PER_MS(CYC_PER_MS)) i_swdv_checker (.clk(clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .status_signals(status_signals),
  .switch_func_code(switch_func_code), .diff_output_a(diff_output_a),
  .diff_output_b(diff_output_b), .diff_output_en(diff_output_en),
  .virtual_input_zero_code(virtual_input_zero_code), .virtual_input_zero(virtual_input_zero));

// *** test/swdv_panel.sv ***
// Model of the front push switch and the differential line receiver
`timescale 1ns/1ps
module swdv_panel (
  input  wire logic clk,
  input  wire logic press,
  input  wire logic diff_output_a,
  input  wire logic diff_output_b,
  input  wire logic diff_output_en,
  output logic      extended_switch_input,
  output logic      rx_a,
  output logic      rx_b
);
  logic last_a, last_b;
  // Contact level follows the operator, high while pressed
  assign extended_switch_input = press;
  always @(posedge clk) begin
    if (diff_output_en) begin
      last_a <= diff_output_a;
      last_b <= diff_output_b;
    end
  end
  // Released lines show the inverse of the last level so stale data never looks valid
  assign rx_a = diff_output_en ? diff_output_a : ~last_a;
  assign rx_b = diff_output_en ? diff_output_b : ~last_b;
endmodule

// *** test/swdv_top_tb.sv ***
// Self-checking testbench for the switch, differential output and virtual input logic
`timescale 1ns/1ps
module swdv_top_tb;
  import swdv_pkg::*;
  // Short millisecond so that 0.1 s timings stay brief
  localparam int MS    = 10;
  localparam int TICK  = 100 * MS;
  localparam int LIMIT = 30000;
  logic         clk     = 1'b0;
  logic         rst     = 1'b1;
  logic         psel    = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite  = 1'b0;
  logic [7:0]   paddr   = 8'h00;
  logic [31:0]  pwdata  = 32'h0;
  logic [255:0] stat    = {127'h0, 1'b1, 128'h0};
  logic         ph_a    = 1'b0;
  logic         ph_b    = 1'b0;
  logic         press   = 1'b0;
  logic [31:0]  prdata;
  logic [7:0]   sw_code, vin_code;
  logic         pready, pslverr, sw_in, sw_lvl, led, out_a, out_b, out_en, vin, rx_a, rx_b;
  int           fail_count = 0;
  int           checked    = 0;
  int           cycles     = 0;
  always #2.5 clk = ~clk;
  swdv_top #(.CYC_PER_MS(MS)) i_swdv_top (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .extended_switch_input(sw_in), .status_signals(stat), .phase_a(ph_a), .phase_b(ph_b),
    .switch_func_code(sw_code), .switch_func_level(sw_lvl), .monitor_led(led),
    .diff_output_a(out_a), .diff_output_b(out_b), .diff_output_en(out_en),
    .virtual_input_zero_code(vin_code), .virtual_input_zero(vin));
  swdv_panel i_swdv_panel (.clk(clk), .press(press), .diff_output_a(out_a),
    .diff_output_b(out_b), .diff_output_en(out_en), .extended_switch_input(sw_in),
    .rx_a(rx_a), .rx_b(rx_b));
  // ----------------------------
  // Shared tasks
  // ----------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rng(input int n, input int lo, input int hi);
    checked++;
    if (n < lo || n > hi) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h to %h", $time, n, lo, hi);
    end
  endtask
  // Holds the request until pready is seen high with penable
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_for(ref logic s, input logic v, input int lim, output int n);
    n = 0;
    while (s !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic count_high(ref logic s, input int len, output int n);
    n = 0;
    repeat (len) begin
      @(negedge clk);
      if (s === 1'b1) n++;
    end
  endtask
  // ----------------------------
  // Scenarios
  // ----------------------------
  task automatic t_reset();
    cyc(2);
    chk({24'h0, sw_code}, 32'h9);
    chk({24'h0, vin_code}, 32'h0);
    chk({31'h0, out_en}, 32'h1);
    rd(OFF_SW_CFG, 32'h0000_0009);
    rd(OFF_SW_TIME, 32'h000A_1E0A);
    rd(OFF_DMODE, 32'h0);
    rd(OFF_DA_CFG, 32'h80);
    rd(OFF_DB_CFG, 32'h80);
    rd(OFF_VIN_CFG, 32'h8000);
    rd(OFF_STATUS, 32'h0);
    wr(8'h1C, 32'hFFFF_FFFF);
    rd(8'h1C, 32'h0);
  endtask
  task automatic t_switch();
    int n;
    int m;
    wr(OFF_SW_TIME, 32'h0002_0302);
    wr(OFF_SW_CFG, 32'h0000_0105);
    cyc(2);
    chk({24'h0, sw_code}, 32'h5);
    chk({31'h0, sw_lvl}, 32'h1);
    @(posedge clk);
    press <= 1'b1;
    wait_for(led, 1'b1, 3 * TICK, n);
    rng(n, TICK, 2 * TICK + 10);
    cyc(3);
    chk({31'h0, sw_lvl}, 32'h0);
    cyc(500);
    chk({31'h0, led}, 32'h1);
    cyc(1000);
    chk({31'h0, sw_lvl}, 32'h0);
    wait_for(sw_lvl, 1'b1, 2 * TICK, m);
    rng(m + 1503, 2 * TICK - 5, 3 * TICK + 10);
    cyc(20);
    chk({31'h0, led}, 32'h0);
    @(posedge clk);
    press <= 1'b0;
    wr(OFF_SW_TIME, 32'h0002_0300);
    wr(OFF_SW_CFG, 32'h0000_0009);
    press <= 1'b1;
    cyc(8);
    chk({31'h0, sw_lvl}, 32'h1);
    @(posedge clk);
    press <= 1'b0;
    cyc(8);
    chk({31'h0, sw_lvl}, 32'h0);
  endtask
  task automatic t_diff();
    logic [7:0] modes [3] = '{8'hFF, 8'h00, 8'h08};
    int n;
    for (int i = 0; i < 3; i++) begin
      wr(OFF_DMODE, {24'h0, modes[i]});
      cyc(2);
      chk({31'h0, out_en}, {31'h0, (i != 0)});
      if (i == 1) begin
        @(posedge clk);
        ph_a <= 1'b1;
        cyc(3);
        chk({30'h0, rx_a, rx_b}, 32'h2);
        @(posedge clk);
        ph_a <= 1'b0;
        ph_b <= 1'b1;
        cyc(3);
        chk({30'h0, rx_a, rx_b}, 32'h1);
      end
    end
    wr(OFF_DA_CFG, 32'h0003_0005);
    wr(OFF_DB_CFG, 32'h0000_0180);
    stat[5] <= 1'b1;
    cyc(3);
    chk({30'h0, rx_a, rx_b}, 32'h3);
    @(posedge clk);
    stat[5] <= 1'b0;
    cyc(15);
    chk({31'h0, rx_a}, 32'h1);
    wait_for(out_a, 1'b0, 40, n);
    rng(n + 15, 2 * MS, 3 * MS + 3);
    wr(OFF_DA_CFG, 32'h0000_0105);
    cyc(3);
    chk({31'h0, rx_a}, 32'h1);
    @(posedge clk);
    stat[5] <= 1'b1;
    cyc(3);
    chk({31'h0, rx_a}, 32'h0);
  endtask
  task automatic t_vin();
    int n;
    wr(OFF_VIN_CFG, 32'h0200_0607);
    cyc(2);
    chk({24'h0, vin_code}, 32'h7);
    @(posedge clk);
    stat[6] <= 1'b1;
    wait_for(vin, 1'b1, 40, n);
    rng(n, MS, 2 * MS + 3);
    @(posedge clk);
    stat[6] <= 1'b0;
    wait_for(vin, 1'b0, 10, n);
    rng(n, 0, 2);
    @(posedge clk);
    stat[6] <= 1'b1;
    cyc(5);
    @(posedge clk);
    stat[6] <= 1'b0;
    count_high(vin, 30, n);
    rng(n, 0, 0);
    @(posedge clk);
    stat[6] <= 1'b1;
    wr(OFF_VIN_CFG, 32'h0003_0607);
    stat[6] <= 1'b0;
    count_high(vin, 50, n);
    rng(n, 1, 1);
    wr(OFF_VIN_CFG, 32'h0001_0607);
    cyc(2);
    count_high(vin, 50, n);
    rng(n, 50, 50);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fail_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_switch();
    t_diff();
    t_vin();
    report_and_stop();
  end
endmodule
